// *** logic/bioem_pkg.sv ***
// Package for the bus I/O enable mapper: register map, field positions, codes.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package bioem_pkg;
   localparam int          AXI_AW            = 8;
   localparam logic [7:0]  ADDR_CTRL         = 8'h00;
   localparam logic [7:0]  ADDR_STATUS       = 8'h04;
   localparam logic [7:0]  ADDR_SLAVE_ADDR   = 8'h08;
   localparam logic [7:0]  ADDR_BUS_IN       = 8'h0C;
   localparam logic [7:0]  ADDR_BUS_OUT      = 8'h10;
   localparam int          BUS_BITS          = 4;
   localparam int          IN_EN_RIGHT       = 0;
   localparam int          IN_EN_LEFT        = 1;
   localparam int          IN_FIXFREQ2       = 2;
   localparam int          IN_ACK            = 3;
   localparam int          CTRL_COMM_OK      = 0;
   localparam int          CTRL_FAULT_SET    = 1;
   localparam int          CTRL_WARNING      = 2;
   localparam int          CTRL_START_DIS    = 3;
   localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
   localparam logic [4:0]  SLAVE_ADDR_RESET  = 5'h00;
   localparam logic [1:0]  RESP_OKAY         = 2'b00;
   localparam logic [1:0]  RESP_SLVERR       = 2'b10;
   typedef enum logic [1:0] {
      BIOEM_ST_ERROR   = 2'b00,
      BIOEM_ST_WARNING = 2'b01,
      BIOEM_ST_START_DIS = 2'b10,
      BIOEM_ST_READY   = 2'b11
   } bioem_state_t;
   typedef enum logic [1:0] {
      BIOEM_DIR_OFF   = 2'b00,
      BIOEM_DIR_RIGHT = 2'b01,
      BIOEM_DIR_LEFT  = 2'b10
   } bioem_dir_t;
endpackage

// *** logic/bioem_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes the destination runs on aclk.
`timescale 1ns/1ps
module bioem_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= meta_next;
         q_reg    <= q_next;
      end
   end

   assign q = q_reg;
endmodule // bioem_sync

// *** logic/bioem_rise.sv ***
// Rising-edge detector on a synchronous level.
// Assumes the input is already in the aclk domain.
`timescale 1ns/1ps
module bioem_rise (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic sample,
   input  wire logic d,
   output logic      rise
);
   logic last_reg;
   logic last_next;

   always_comb begin
      last_next = sample ? d : last_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= last_next;
      end
   end

   assign rise = sample & d & ~last_reg;
endmodule // bioem_rise

// *** logic/bioem_mapper.sv ***
// Bus I/O enable mapper: fieldbus reference bits to drive control and status.
// Assumes the bus slave front end delivers bits with a one-cycle exchange strobe.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - Inbound bit0 right enable, bit1 left enable, bit2 fixed frequency 2, bit3 acknowledge.
// - Enables 01 run right, 10 run left, 00 and 11 motor off.
// - Fault clears only on acknowledge rising edge; enable edges never acknowledge.
// - Outbound bits1:0 drive state code; bits 2,3 mirror digital inputs 1,2.
// - Local digital input enable present means bus enable and fixed frequency 2 bits are ignored.
// - Bus fault acknowledge is accepted whenever the link is up, even under local control.
// - Both enables together drop enable and stop at once, no ramp.
// - Communication loss or cable off removes bus enable, motor off under bus control.
// - Slave address resets to 0, shown as new unaddressed slave.
// - Four reference bits each direction every bus cycle.
module bioem_mapper
   import bioem_pkg::*;
(
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [bioem_pkg::AXI_AW-1:0]  s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [bioem_pkg::AXI_AW-1:0]  s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [bioem_pkg::BUS_BITS-1:0] bus_in_bits,
   input  wire logic                          bus_exchange,
   input  wire logic                          bus_comm_ok,
   output logic [bioem_pkg::BUS_BITS-1:0]     bus_out_bits,
   input  wire logic                          din1_pin,
   input  wire logic                          din2_pin,
   input  wire logic                          local_enable_right_pin,
   input  wire logic                          local_enable_left_pin,
   input  wire logic                          fault_pin,
   output logic                               run_right,
   output logic                               run_left,
   output logic                               fixed_freq2_sel,
   output logic                               fault_active,
   output logic [4:0]                         slave_address,
   output logic                               slave_unaddressed
);
   import bioem_pkg::*;

   // Pins from outside the clock domain
   logic [4:0] pins_sync;
   bioem_sync #(.W(5)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({fault_pin, local_enable_left_pin, local_enable_right_pin, din2_pin, din1_pin}),
      .q       (pins_sync)
   );
   logic din1_s, din2_s, loc_r_s, loc_l_s, fault_s;
   assign {fault_s, loc_l_s, loc_r_s, din2_s, din1_s} = pins_sync;

   // Software-visible control and address
   logic [31:0] ctrl_reg, ctrl_next;
   logic [4:0]  addr_reg, addr_next;

   // Exchange-latched inbound bits
   logic [BUS_BITS-1:0] in_reg, in_next;
   logic [BUS_BITS-1:0] out_reg, out_next;
   logic                fault_reg, fault_next;

   logic link_up;
   assign link_up = bus_comm_ok & ctrl_reg[CTRL_COMM_OK];

   logic ack_rise;
   bioem_rise u_ack (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sample  (bus_exchange & link_up),
      .d       (bus_in_bits[IN_ACK]),
      .rise    (ack_rise)
   );

   logic local_en;
   logic bus_r, bus_l;
   logic cmd_r, cmd_l;
   assign local_en = loc_r_s | loc_l_s;
   assign bus_r    = link_up & in_reg[IN_EN_RIGHT];
   assign bus_l    = link_up & in_reg[IN_EN_LEFT];
   assign cmd_r    = local_en ? loc_r_s : bus_r;
   assign cmd_l    = local_en ? loc_l_s : bus_l;

   bioem_dir_t dir;
   always_comb begin
      dir = BIOEM_DIR_OFF;
      if (!fault_reg) begin
         case ({cmd_l, cmd_r})
            2'b01:   dir = BIOEM_DIR_RIGHT;
            2'b10:   dir = BIOEM_DIR_LEFT;
            default: dir = BIOEM_DIR_OFF;
         endcase
      end
   end

   bioem_state_t drv_state;
   always_comb begin
      if (fault_reg) begin
         drv_state = BIOEM_ST_ERROR;
      end else if (ctrl_reg[CTRL_WARNING]) begin
         drv_state = BIOEM_ST_WARNING;
      end else if (ctrl_reg[CTRL_START_DIS]) begin
         drv_state = BIOEM_ST_START_DIS;
      end else begin
         drv_state = BIOEM_ST_READY;
      end
   end

   always_comb begin
      in_next         = in_reg;
      out_next        = out_reg;
      fault_next      = fault_reg;
      if (!link_up) begin
         in_next = '0;
      end else if (bus_exchange) begin
         in_next = bus_in_bits;
      end
      if (bus_exchange) begin
         out_next = {din2_s, din1_s, drv_state};
      end
      // Fault source wins over a same-cycle acknowledge
      if (fault_s || ctrl_reg[CTRL_FAULT_SET]) begin
         fault_next = 1'b1;
      end else if (ack_rise) begin
         fault_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_reg         <= '0;
         out_reg        <= {2'b00, BIOEM_ST_READY};
         fault_reg      <= 1'b0;
      end else begin
         in_reg         <= in_next;
         out_reg        <= out_next;
         fault_reg      <= fault_next;
      end
   end

   // AXI4-Lite slave, one write and one read at a time
   logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [7:0]  awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0]  wstrb_reg, wstrb_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;

   assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
   assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
   assign s_axi_arready = ~rvalid_reg;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      logic [31:0] m;
      m            = '0;
      aw_hold_next = aw_hold_reg;
      w_hold_next  = w_hold_reg;
      awaddr_next  = awaddr_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      ctrl_next    = ctrl_reg;
      addr_next    = addr_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
      end
      if (aw_hold_reg && w_hold_reg) begin
         aw_hold_next = 1'b0;
         w_hold_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = RESP_OKAY;
         if (awaddr_reg == ADDR_CTRL) begin
            ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg);
         end else if (awaddr_reg == ADDR_SLAVE_ADDR) begin
            m = merge({27'h0, addr_reg}, wdata_reg, wstrb_reg);
            addr_next = m[4:0];
         end else if (awaddr_reg == ADDR_STATUS || awaddr_reg == ADDR_BUS_IN || awaddr_reg == ADDR_BUS_OUT) begin
            bresp_next = RESP_OKAY;
         end else begin
            bresp_next = RESP_SLVERR;
         end
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         if (s_axi_araddr == ADDR_CTRL) begin
            rdata_next = ctrl_reg;
         end else if (s_axi_araddr == ADDR_STATUS) begin
            rdata_next = {25'h0, local_en, run_left, run_right, fault_reg, link_up, drv_state};
         end else if (s_axi_araddr == ADDR_SLAVE_ADDR) begin
            rdata_next = {27'h0, addr_reg};
         end else if (s_axi_araddr == ADDR_BUS_IN) begin
            rdata_next = {28'h0, in_reg};
         end else if (s_axi_araddr == ADDR_BUS_OUT) begin
            rdata_next = {28'h0, out_reg};
         end else begin
            rdata_next = '0;
            rresp_next = RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
         ctrl_reg    <= CTRL_RESET;
         addr_reg    <= SLAVE_ADDR_RESET;
      end else begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg  <= w_hold_next;
         awaddr_reg  <= awaddr_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
         ctrl_reg    <= ctrl_next;
         addr_reg    <= addr_next;
      end
   end

   // Outputs; direction combinational so a double enable stops in the same cycle
   assign run_right         = (dir == BIOEM_DIR_RIGHT);
   assign run_left          = (dir == BIOEM_DIR_LEFT);
   assign fixed_freq2_sel   = ~local_en & link_up & in_reg[IN_FIXFREQ2];
   assign fault_active      = fault_reg;
   assign bus_out_bits      = out_reg;
   assign slave_address     = addr_reg;
   assign slave_unaddressed = (addr_reg == 5'h00);
   assign s_axi_bvalid      = bvalid_reg;
   assign s_axi_bresp       = bresp_reg;
   assign s_axi_rvalid      = rvalid_reg;
   assign s_axi_rdata       = rdata_reg;
   assign s_axi_rresp       = rresp_reg;
endmodule // bioem_mapper

// *** verification/bioem_mapper_monitor.sv ***
// Checker for the enable mapper: bus bits, drive outputs, address flag.
// Assumes binding to bioem_mapper; sees its ports only.
`timescale 1ns/1ps
module bioem_mapper_monitor (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic [3:0] bus_in_bits,
   input wire logic       bus_exchange,
   input wire logic       bus_comm_ok,
   input wire logic [3:0] bus_out_bits,
   input wire logic       din1_pin,
   input wire logic       din2_pin,
   input wire logic       local_enable_right_pin,
   input wire logic       local_enable_left_pin,
   input wire logic       run_right,
   input wire logic       run_left,
   input wire logic       fault_active,
   input wire logic [4:0] slave_address,
   input wire logic       slave_unaddressed
);
   import bioem_pkg::*;
   logic [2:0] ack_age_reg;
   logic [2:0] ack_age_next;
   default clocking mon_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Cycles since an acknowledge was seen at an exchange, saturating
   always_comb begin
      ack_age_next = ack_age_reg;
      if (bus_exchange && bus_in_bits[IN_ACK]) ack_age_next = 3'h0;
      else if (ack_age_reg != 3'h7) ack_age_next = ack_age_reg + 3'h1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) ack_age_reg <= 3'h7;
      else ack_age_reg <= ack_age_next;
   end
   property p_no_both; !(run_right && run_left); endproperty
   a_no_both: assert property (p_no_both) else $error("both run outputs high");
   // Four cycles cover the two-flop lag of the local pins
   property p_link_off; (!bus_comm_ok && !local_enable_right_pin && !local_enable_left_pin) [*4]
      |-> !run_right && !run_left; endproperty
   a_link_off: assert property (p_link_off) else $error("run without link");
   property p_loc; (local_enable_left_pin && !local_enable_right_pin) [*4] |-> !run_right; endproperty
   a_loc: assert property (p_loc) else $error("bus enable beat local enable");
   property p_out_hold; !$past(bus_exchange) |-> $stable(bus_out_bits); endproperty
   a_out_hold: assert property (p_out_hold) else $error("outbound changed off exchange");
   property p_mirror; $stable({din2_pin, din1_pin}) [*3] ##0 bus_exchange
      |=> bus_out_bits[3:2] == $past({din2_pin, din1_pin}, 2); endproperty
   a_mirror: assert property (p_mirror) else $error("outbound input bits wrong");
   property p_err_code; bus_exchange && fault_active |=> bus_out_bits[1:0] == BIOEM_ST_ERROR; endproperty
   a_err_code: assert property (p_err_code) else $error("error code missing");
   property p_ack_clear; $fell(fault_active) |-> ack_age_reg < 3'h4; endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("fault cleared without ack");
   property p_unaddr; slave_unaddressed == (slave_address == 5'h00); endproperty
   a_unaddr: assert property (p_unaddr) else $error("unaddressed flag wrong");
   // Reset default must be the unaddressed state, not just a consistent flag
   property p_addr_rst; $past(!aresetn) |-> slave_unaddressed && slave_address == 5'h00; endproperty
   a_addr_rst: assert property (p_addr_rst) else $error("address not zero after reset");
   c_ack: cover property ($fell(fault_active));
   c_right: cover property ($rose(run_right));
   c_local: cover property (local_enable_left_pin && run_left);
endmodule // bioem_mapper_monitor
bind bioem_mapper bioem_mapper_monitor i_bioem_mapper_monitor (.aclk, .aresetn, .bus_in_bits,
   .bus_exchange, .bus_comm_ok, .bus_out_bits, .din1_pin, .din2_pin, .local_enable_right_pin,
   .local_enable_left_pin, .run_right, .run_left, .fault_active, .slave_address, .slave_unaddressed);

// *** verification/bioem_bus_master.sv ***
// Cyclic bus master model: one exchange every CYC cycles while linked.
// Assumes the bench sets the command bits and the link state.
`timescale 1ns/1ps
module bioem_bus_master #(
   parameter int CYC = 8
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [3:0] cmd,
   input  wire logic       link_ok,
   input  wire logic [3:0] bus_out_bits,
   output logic [3:0]      bus_in_bits,
   output logic            bus_exchange,
   output logic            bus_comm_ok,
   output logic [3:0]      rx_bits
);
   int   cnt = 0;
   logic err = 1'b0;
   initial bus_in_bits = 4'h0;
   initial bus_exchange = 1'b0;
   initial rx_bits = 4'h0;
   assign bus_comm_ok = link_ok;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 0;
         err <= 1'b0;
         bus_exchange <= 1'b0;
      end else begin
         cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
         bus_exchange <= (cnt == CYC - 1) && link_ok;
         if (!link_ok) err <= 1'b1;
         else if (cmd == 4'h0) err <= 1'b0;
         // Bits are only valid at the exchange; garbage in between
         if (cnt == CYC - 1) bus_in_bits <= (err || !link_ok) ? 4'h0 : cmd;
         else bus_in_bits <= ~bus_in_bits;
         if (bus_exchange) rx_bits <= bus_out_bits;
      end
   end
endmodule // bioem_bus_master

// *** verification/test_bus_io_enable_mapper.sv ***
// Bench for bioem_mapper with a cyclic bus master model.
// Assumes 100 MHz aclk and AXI4-Lite register access.
`timescale 1ns/1ps
module test_bus_io_enable_mapper;
   import bioem_pkg::*;
   localparam int CYC = 8;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, link_ok;
   logic [7:0] s_axi_awaddr, s_axi_araddr, snap;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, bus_in_bits, bus_out_bits, cmd, rx_bits;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic bus_exchange, bus_comm_ok, din1_pin, din2_pin, local_enable_right_pin, local_enable_left_pin;
   logic fault_pin, run_right, run_left, fixed_freq2_sel, fault_active, slave_unaddressed;
   logic [4:0] slave_address;
   int bad_count, n_checks;
   logic [3:0] cmds [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h0};
   logic [7:0] exps [5] = '{8'h31, 8'h32, 8'h30, 8'h34, 8'h30};
   bioem_mapper i_bioem_mapper (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .bus_in_bits, .bus_exchange, .bus_comm_ok, .bus_out_bits,
      .din1_pin, .din2_pin, .local_enable_right_pin, .local_enable_left_pin, .fault_pin, .run_right,
      .run_left, .fixed_freq2_sel, .fault_active, .slave_address, .slave_unaddressed);
   bioem_bus_master #(.CYC(CYC)) i_bioem_bus_master (.aclk, .aresetn, .cmd, .link_ok,
      .bus_out_bits, .bus_in_bits, .bus_exchange, .bus_comm_ok, .rx_bits);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic end_sim;
      $display("checks=%0d errors=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Snapshot {received outbound, fault, fixed freq, left, right} after three exchanges
   task automatic go(input logic [3:0] c, input logic [7:0] e);
      cmd <= c;
      repeat (3 * CYC) @(posedge aclk);
      @(negedge aclk);
      snap = {rx_bits, fault_active, fixed_freq2_sel, run_left, run_right};
      @(posedge aclk);
      chk({24'h0, snap}, {24'h0, e});
   endtask
   // Ready is judged at the falling edge, so the request holds through the taking edge
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ta, tw, tr, v;
      logic [31:0] q;
      logic [1:0] r;
      v = 1'b0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_arvalid <= !wr;
      s_axi_bready <= wr;
      s_axi_rready <= !wr;
      for (n = 0; n < 50 && !v; n++) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         v = wr ? s_axi_bvalid : s_axi_rvalid;
         r = wr ? s_axi_bresp : s_axi_rresp;
         q = s_axi_rdata;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
      chk({31'h0, v}, 32'h1);
      if (!v) end_sim();
      if (!wr) chk(q, d);
      chk({30'h0, r}, {30'h0, er});
   endtask
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      {din1_pin, din2_pin, local_enable_right_pin, local_enable_left_pin, fault_pin} = 5'h00;
      cmd = 4'h0;
      link_ok = 1'b1;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      acc(1'b0, ADDR_SLAVE_ADDR, 32'h0, RESP_OKAY);
      chk({31'h0, slave_unaddressed}, 32'h1);
      acc(1'b0, ADDR_CTRL, CTRL_RESET, RESP_OKAY);
      acc(1'b0, ADDR_BUS_OUT, 32'h3, RESP_OKAY);
      acc(1'b0, 8'h40, 32'h0, RESP_SLVERR);
      acc(1'b1, 8'h40, 32'h5, RESP_SLVERR);
      acc(1'b1, ADDR_CTRL, 32'h1, RESP_OKAY);
      for (int i = 0; i < 5; i++) go(cmds[i], exps[i]);
      go(4'h1, 8'h31);
      link_ok <= 1'b0;
      go(4'h1, 8'h30);
      link_ok <= 1'b1;
      go(4'h1, 8'h30);
      go(4'h0, 8'h30);
      go(4'h1, 8'h31);
      fault_pin <= 1'b1;
      go(4'h1, 8'h08);
      fault_pin <= 1'b0;
      go(4'h0, 8'h08);
      go(4'h1, 8'h08);
      go(4'h8, 8'h30);
      din1_pin <= 1'b1;
      local_enable_left_pin <= 1'b1;
      go(4'h1, 8'h72);
      fault_pin <= 1'b1;
      go(4'h1, 8'h48);
      fault_pin <= 1'b0;
      go(4'h0, 8'h48);
      go(4'h8, 8'h72);
      local_enable_left_pin <= 1'b0;
      local_enable_right_pin <= 1'b1;
      go(4'h2, 8'h71);
      local_enable_right_pin <= 1'b0;
      go(4'h0, 8'h70);
      acc(1'b1, ADDR_CTRL, 32'h5, RESP_OKAY);
      go(4'h0, 8'h50);
      acc(1'b1, ADDR_CTRL, 32'h9, RESP_OKAY);
      go(4'h0, 8'h60);
      acc(1'b1, ADDR_CTRL, 32'h3, RESP_OKAY);
      go(4'h0, 8'h48);
      acc(1'b1, ADDR_CTRL, 32'h1, RESP_OKAY);
      go(4'h0, 8'h48);
      go(4'h8, 8'h70);
      din1_pin <= 1'b0;
      din2_pin <= 1'b1;
      go(4'h0, 8'hB0);
      // Master off the network while the address is programmed
      link_ok <= 1'b0;
      acc(1'b1, ADDR_SLAVE_ADDR, 32'h0A, RESP_OKAY);
      acc(1'b0, ADDR_SLAVE_ADDR, 32'h0A, RESP_OKAY);
      chk({27'h0, slave_address}, 32'h0A);
      chk({31'h0, slave_unaddressed}, 32'h0);
      acc(1'b1, ADDR_BUS_OUT, 32'hFF, RESP_OKAY);
      acc(1'b0, ADDR_BUS_OUT, 32'hB, RESP_OKAY);
      acc(1'b0, ADDR_BUS_IN, 32'h0, RESP_OKAY);
      end_sim();
   end
endmodule // test_bus_io_enable_mapper
